// ===== rtl/fscrc_pkg.sv
// shared constants, types and checksum for the flow sensor readout link
package fscrc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int                 CLK_NS      = 20;
  localparam int                 SCL_NS      = 1000;
  localparam logic [7:0]         QUARTER_CYC = 8'(SCL_NS / 4 / CLK_NS);

  // ----------------------------------------------------------------
  // link constants
  // ----------------------------------------------------------------
  localparam logic [6:0]         DEV_ADDR    = 7'h40;
  localparam logic [15:0]        CMD_ID1     = 16'h367C;
  localparam logic [15:0]        CMD_ID2     = 16'hE102;
  localparam logic [7:0]         CRC_POLY    = 8'h31;
  localparam logic [7:0]         CRC_INIT    = 8'hFF;
  localparam logic [7:0]         CRC_XOR     = 8'h00;
  localparam logic [3:0]         BIT_LAST    = 4'h8;
  localparam logic [1:0]         POS_CRC     = 2'h2;
  localparam logic [1:0]         TXN_READ    = 2'h2;
  localparam logic [4:0]         WR_LAST     = 5'h02;
  localparam logic [4:0]         ID_LAST     = 5'h12;
  localparam logic [4:0]         MEAS_LAST   = 5'h06;
  localparam logic [1:0]         WR_CMD_LEN  = 2'h2;

  // ----------------------------------------------------------------
  // output word limits and scale factors
  // ----------------------------------------------------------------
  localparam logic [15:0]        FLOW_MAX    = 16'h6590;
  localparam logic [15:0]        FLOW_MIN    = 16'h9A70;
  localparam logic signed [15:0] FLOW_SCALE  = 16'sh0014;
  localparam logic signed [15:0] TEMP_SCALE  = 16'sh00C8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic               SDA_REL     = 1'b1;
  localparam logic               SCL_IDLE    = 1'b1;

  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_ADDR = 6'h02,
    D_WACK = 6'h04,
    D_WR   = 6'h08,
    D_RD   = 6'h10,
    D_RACK = 6'h20
  } fscrc_dstate_t;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } fscrc_hstate_t;

  function automatic logic [7:0] crc8(input logic [15:0] data);
    logic [7:0] crc;
    crc = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (crc[7] ^ data[i]) crc = {crc[6:0], 1'b0} ^ CRC_POLY;
      else crc = {crc[6:0], 1'b0};
    end
    return crc ^ CRC_XOR;
  endfunction

endpackage

// ===== rtl/fscrc_if.sv
// two-wire link between host and sensor ends
interface fscrc_if;
  logic scl;
  logic sda;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;

  // open-drain wired and of both ends
  assign sda = (sda_dev_oe_n | sda_dev_o) & (sda_host_oe_n | sda_host_o);

  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe_n);
  modport host (output scl, input sda, output sda_host_o, output sda_host_oe_n);
endinterface

// ===== rtl/fscrc_dev.sv
// sensor end: two-wire target returning identification, flow and temperature words
//
// Functional notes
// R1: host writes commands 367C then E102 separately
// R2: read after commands returns six words plus checksums
// R3: product then serial, most significant byte first
// R4: 32-bit product code, low byte is revision
// R5: 64-bit serial number unique per unit
// R6: checksum covers only the preceding word
// R7: crc-8, poly 31, init FF, no reflection
// R8: flow word signed, clamped to 26000 counts
// R9: host divides flow word by 20
// R10: temperature signed word, host divides by 200
// R11: host flags words with checksum mismatch invalid
module fscrc_dev #(
  // arbitrary neutral product code
  parameter logic [23:0] PROD_CODE = 24'h5A5A5A
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  fscrc_if.dev             link,
  input  wire logic [7:0]  revision,
  input  wire logic [63:0] serial_no,
  input  wire logic [15:0] flow_raw,
  input  wire logic [15:0] temp_raw,
  output logic             id_armed
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_d_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic sda_d_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_reg <= fscrc_pkg::SCL_IDLE;
      scl_s2_reg <= fscrc_pkg::SCL_IDLE;
      scl_d_reg  <= fscrc_pkg::SCL_IDLE;
      sda_s1_reg <= fscrc_pkg::SDA_REL;
      sda_s2_reg <= fscrc_pkg::SDA_REL;
      sda_d_reg  <= fscrc_pkg::SDA_REL;
    end else begin
      scl_s1_reg <= link.scl;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_rise = scl_s2_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s2_reg & scl_d_reg;
  assign start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign stop_ev  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // ----------------------------------------------------------------
  // word selection and checksum
  // ----------------------------------------------------------------
  fscrc_pkg::fscrc_dstate_t state_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  sh_reg;
  logic        rw_reg;
  logic        nack_reg;
  logic [2:0]  word_idx_reg;
  logic [1:0]  pos_reg;
  logic        id_mode_reg;
  logic [95:0] id_bits;
  logic [15:0] flow_word;
  logic [15:0] cur_word;
  logic [7:0]  tx_byte;

  assign id_bits = {PROD_CODE, revision, serial_no}; // R4 R5

  always_comb begin
    flow_word = flow_raw;
    if ($signed(flow_raw) > $signed(fscrc_pkg::FLOW_MAX)) flow_word = fscrc_pkg::FLOW_MAX; // R8
    else if ($signed(flow_raw) < $signed(fscrc_pkg::FLOW_MIN)) flow_word = fscrc_pkg::FLOW_MIN; // R8
  end

  always_comb begin
    cur_word = 16'hFFFF;
    if (id_mode_reg) begin
      case (word_idx_reg) // R3
        3'h0:    cur_word = id_bits[95:80];
        3'h1:    cur_word = id_bits[79:64];
        3'h2:    cur_word = id_bits[63:48];
        3'h3:    cur_word = id_bits[47:32];
        3'h4:    cur_word = id_bits[31:16];
        3'h5:    cur_word = id_bits[15:0];
        default: cur_word = 16'hFFFF;
      endcase
    end else begin
      case (word_idx_reg)
        3'h0:    cur_word = flow_word; // R8
        3'h1:    cur_word = temp_raw; // R10
        default: cur_word = 16'hFFFF;
      endcase
    end
  end

  always_comb begin
    case (pos_reg)
      2'h0:    tx_byte = cur_word[15:8]; // R3
      2'h1:    tx_byte = cur_word[7:0];
      default: tx_byte = fscrc_pkg::crc8(cur_word); // R6 R7
    endcase
  end

  // ----------------------------------------------------------------
  // byte events
  // ----------------------------------------------------------------
  logic addr_done;
  logic addr_hit;
  logic wr_done;
  logic rd_first;
  logic rd_next;

  assign addr_done = (state_reg == fscrc_pkg::D_ADDR) && scl_fall && (cnt_reg == fscrc_pkg::BIT_LAST);
  assign addr_hit  = addr_done && (sh_reg[7:1] == fscrc_pkg::DEV_ADDR);
  assign wr_done   = (state_reg == fscrc_pkg::D_WR) && scl_fall && (cnt_reg == fscrc_pkg::BIT_LAST);
  assign rd_first  = (state_reg == fscrc_pkg::D_WACK) && scl_fall && rw_reg;
  assign rd_next   = (state_reg == fscrc_pkg::D_RACK) && scl_fall && !nack_reg;

  // ----------------------------------------------------------------
  // bit-level target state machine
  // ----------------------------------------------------------------
  logic [7:0] tx_reg;
  logic       sda_oe_n_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= fscrc_pkg::D_IDLE;
      cnt_reg      <= 4'h0;
      sh_reg       <= 8'h00;
      tx_reg       <= 8'hFF;
      rw_reg       <= 1'b0;
      nack_reg     <= 1'b0;
      sda_oe_n_reg <= fscrc_pkg::SDA_REL;
    end else if (start_ev) begin
      state_reg    <= fscrc_pkg::D_ADDR;
      cnt_reg      <= 4'h0;
      sda_oe_n_reg <= fscrc_pkg::SDA_REL;
    end else if (stop_ev) begin
      state_reg    <= fscrc_pkg::D_IDLE;
      sda_oe_n_reg <= fscrc_pkg::SDA_REL;
    end else begin
      case (state_reg)
        fscrc_pkg::D_ADDR, fscrc_pkg::D_WR: begin
          if (scl_rise) begin
            sh_reg  <= {sh_reg[6:0], sda_s2_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (addr_done && !addr_hit) begin
            state_reg <= fscrc_pkg::D_IDLE;
          end else if (addr_hit || wr_done) begin
            if (addr_hit) rw_reg <= sh_reg[0];
            sda_oe_n_reg <= 1'b0;
            state_reg    <= fscrc_pkg::D_WACK;
          end
        end
        fscrc_pkg::D_WACK: begin
          if (rd_first) begin
            tx_reg       <= tx_byte; // R2
            sda_oe_n_reg <= tx_byte[7];
            cnt_reg      <= 4'h0;
            state_reg    <= fscrc_pkg::D_RD;
          end else if (scl_fall) begin
            sda_oe_n_reg <= fscrc_pkg::SDA_REL;
            cnt_reg      <= 4'h0;
            state_reg    <= fscrc_pkg::D_WR;
          end
        end
        fscrc_pkg::D_RD: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h7) begin
              sda_oe_n_reg <= fscrc_pkg::SDA_REL;
              state_reg    <= fscrc_pkg::D_RACK;
            end else begin
              tx_reg       <= {tx_reg[6:0], 1'b1};
              sda_oe_n_reg <= tx_reg[6];
              cnt_reg      <= cnt_reg + 4'h1;
            end
          end
        end
        fscrc_pkg::D_RACK: begin
          if (scl_rise) nack_reg <= sda_s2_reg;
          if (rd_next) begin
            tx_reg       <= tx_byte; // R2
            sda_oe_n_reg <= tx_byte[7];
            cnt_reg      <= 4'h0;
            state_reg    <= fscrc_pkg::D_RD;
          end else if (scl_fall) begin
            state_reg <= fscrc_pkg::D_IDLE;
          end
        end
        fscrc_pkg::D_IDLE: begin
          sda_oe_n_reg <= fscrc_pkg::SDA_REL;
        end
        default: begin
          state_reg    <= fscrc_pkg::D_IDLE;
          sda_oe_n_reg <= fscrc_pkg::SDA_REL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read pointer: word and byte position
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_idx_reg <= 3'h0;
      pos_reg      <= 2'h0;
      id_mode_reg  <= 1'b0;
    end else if (addr_hit) begin
      word_idx_reg <= 3'h0;
      pos_reg      <= 2'h0;
      id_mode_reg  <= id_armed; // R2
    end else if (rd_first || rd_next) begin
      if (pos_reg == fscrc_pkg::POS_CRC) begin
        pos_reg <= 2'h0;
        if (word_idx_reg != 3'h7) word_idx_reg <= word_idx_reg + 3'h1;
      end else begin
        pos_reg <= pos_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // command tracking
  // ----------------------------------------------------------------
  logic [15:0] cmd_reg;
  logic [1:0]  wr_cnt_reg;
  logic        stage1_reg;
  logic        armed_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg    <= 16'h0000;
      wr_cnt_reg <= 2'h0;
      stage1_reg <= 1'b0;
      armed_reg  <= 1'b0;
    end else if (start_ev || stop_ev) begin
      wr_cnt_reg <= 2'h0;
      if (wr_cnt_reg == fscrc_pkg::WR_CMD_LEN) begin
        stage1_reg <= (cmd_reg == fscrc_pkg::CMD_ID1); // R1
        armed_reg  <= (cmd_reg == fscrc_pkg::CMD_ID2) && stage1_reg; // R1
      end else if (wr_cnt_reg != 2'h0) begin
        stage1_reg <= 1'b0;
        armed_reg  <= 1'b0;
      end
    end else if (wr_done) begin
      cmd_reg <= {cmd_reg[7:0], sh_reg};
      if (wr_cnt_reg != 2'h3) wr_cnt_reg <= wr_cnt_reg + 2'h1;
    end else if (addr_hit && sh_reg[0]) begin
      armed_reg  <= 1'b0;
      stage1_reg <= 1'b0;
    end
  end

  assign id_armed          = armed_reg;
  assign link.sda_dev_o    = 1'b0;
  assign link.sda_dev_oe_n = sda_oe_n_reg;

endmodule // fscrc_dev

// ===== rtl/fscrc_host.sv
// host end: two-wire master reading identification and measurement words into a fifo
module fscrc_fifo #(
  parameter int W = 17,
  parameter int D = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;

  assign out_valid = wp_reg != rp_reg;
  assign in_ready  = (wp_reg[AW] == rp_reg[AW]) || (wp_reg[AW-1:0] != rp_reg[AW-1:0]);
  assign out_data  = mem[rp_reg[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (in_valid && in_ready) mem[wp_reg[AW-1:0]] <= in_data;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (in_valid && in_ready) wp_reg <= wp_reg + {{AW{1'b0}}, 1'b1};
      if (out_valid && out_ready) rp_reg <= rp_reg + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // fscrc_fifo

module fscrc_host (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  fscrc_if.host            link,
  input  wire logic        id_req,
  input  wire logic        meas_req,
  output logic             busy,
  output logic             nack_err,
  output logic             crc_err,
  output logic [15:0]      flow_mlph,
  output logic [15:0]      temp_c,
  output logic             word_valid,
  input  wire logic        word_ready,
  output logic [16:0]      word_data
);

  // ----------------------------------------------------------------
  // sda synchroniser and quarter-bit divider
  // ----------------------------------------------------------------
  logic       sda_s1_reg;
  logic       sda_s2_reg;
  logic [7:0] qcnt_reg;
  logic       push_reg;
  logic       tick;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1_reg <= fscrc_pkg::SDA_REL;
      sda_s2_reg <= fscrc_pkg::SDA_REL;
      qcnt_reg   <= 8'h00;
    end else begin
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
      if (tick) qcnt_reg <= 8'h00;
      else if (!push_reg) qcnt_reg <= qcnt_reg + 8'h01;
    end
  end

  assign tick = !push_reg && (qcnt_reg == fscrc_pkg::QUARTER_CYC - 8'h01);

  // ----------------------------------------------------------------
  // master sequencer
  // ----------------------------------------------------------------
  fscrc_pkg::fscrc_hstate_t state_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [8:0] tx_reg;
  logic [8:0] rx_reg;
  logic [4:0] idx_reg;
  logic [1:0] txn_reg;
  logic       idm_reg;
  logic       abort_reg;
  logic       scl_reg;
  logic       oe_n_reg;
  logic [4:0] last_idx;
  logic       go;
  logic       byte_done;
  logic       nack_seen;

  function automatic logic [8:0] frame(input logic [1:0] t, input logic [4:0] i, input logic [4:0] last);
    if (i == 5'h00) return {fscrc_pkg::DEV_ADDR, t == fscrc_pkg::TXN_READ, 1'b1};
    if (t == fscrc_pkg::TXN_READ) return {8'hFF, i == last};
    if (i == 5'h01) return {(t == 2'h0) ? fscrc_pkg::CMD_ID1[15:8] : fscrc_pkg::CMD_ID2[15:8], 1'b1}; // R1
    return {(t == 2'h0) ? fscrc_pkg::CMD_ID1[7:0] : fscrc_pkg::CMD_ID2[7:0], 1'b1}; // R1
  endfunction

  assign go        = (state_reg == fscrc_pkg::H_IDLE) && (id_req || meas_req);
  assign last_idx  = (txn_reg != fscrc_pkg::TXN_READ) ? fscrc_pkg::WR_LAST :
                     idm_reg ? fscrc_pkg::ID_LAST : fscrc_pkg::MEAS_LAST;
  assign byte_done = (state_reg == fscrc_pkg::H_BIT) && tick && (ph_reg == 2'h3) && (bit_reg == fscrc_pkg::BIT_LAST);
  assign nack_seen = rx_reg[0] && ((txn_reg != fscrc_pkg::TXN_READ) || (idx_reg == 5'h00));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fscrc_pkg::H_IDLE;
      ph_reg    <= 2'h0;
      bit_reg   <= 4'h0;
      tx_reg    <= 9'h1FF;
      rx_reg    <= 9'h000;
      idx_reg   <= 5'h00;
      txn_reg   <= 2'h0;
      idm_reg   <= 1'b0;
      abort_reg <= 1'b0;
      scl_reg   <= fscrc_pkg::SCL_IDLE;
      oe_n_reg  <= fscrc_pkg::SDA_REL;
    end else if (go) begin
      state_reg <= fscrc_pkg::H_START;
      ph_reg    <= 2'h0;
      idm_reg   <= id_req;
      abort_reg <= 1'b0;
      txn_reg   <= id_req ? 2'h0 : fscrc_pkg::TXN_READ;
    end else if (tick && (state_reg != fscrc_pkg::H_IDLE)) begin
      ph_reg <= ph_reg + 2'h1;
      case (state_reg)
        fscrc_pkg::H_START: begin
          case (ph_reg)
            2'h0:    oe_n_reg <= fscrc_pkg::SDA_REL;
            2'h1:    scl_reg <= 1'b1;
            2'h2:    oe_n_reg <= 1'b0;
            default: begin
              scl_reg   <= 1'b0;
              idx_reg   <= 5'h00;
              bit_reg   <= 4'h0;
              tx_reg    <= frame(txn_reg, 5'h00, last_idx);
              state_reg <= fscrc_pkg::H_BIT;
            end
          endcase
        end
        fscrc_pkg::H_BIT: begin
          case (ph_reg)
            2'h0:    oe_n_reg <= tx_reg[8];
            2'h1:    scl_reg <= 1'b1;
            2'h2:    rx_reg <= {rx_reg[7:0], sda_s2_reg};
            default: begin
              scl_reg <= 1'b0;
              tx_reg  <= {tx_reg[7:0], 1'b1};
              bit_reg <= bit_reg + 4'h1;
              if (byte_done) begin
                if (nack_seen || (idx_reg == last_idx)) begin
                  abort_reg <= nack_seen;
                  state_reg <= fscrc_pkg::H_STOP;
                end else begin
                  idx_reg <= idx_reg + 5'h01;
                  bit_reg <= 4'h0;
                  tx_reg  <= frame(txn_reg, idx_reg + 5'h01, last_idx);
                end
              end
            end
          endcase
        end
        fscrc_pkg::H_STOP: begin
          case (ph_reg)
            2'h0:    oe_n_reg <= 1'b0;
            2'h1:    scl_reg <= 1'b1;
            2'h2:    oe_n_reg <= fscrc_pkg::SDA_REL;
            default: begin
              if (!abort_reg && (txn_reg != fscrc_pkg::TXN_READ)) begin
                txn_reg   <= txn_reg + 2'h1; // R1
                state_reg <= fscrc_pkg::H_START;
              end else begin
                state_reg <= fscrc_pkg::H_IDLE;
              end
            end
          endcase
        end
        default: state_reg <= fscrc_pkg::H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // received words: checksum, scaling, fifo push
  // ----------------------------------------------------------------
  logic [15:0] word_reg;
  logic [1:0]  pos_reg;
  logic [2:0]  wcnt_reg;
  logic [16:0] push_data_reg;
  logic        push_ready;
  logic        nack_reg;
  logic        crc_err_reg;
  logic [15:0] flow_reg;
  logic [15:0] temp_reg;
  logic        crc_ok;

  assign crc_ok = fscrc_pkg::crc8(word_reg) == rx_reg[8:1]; // R7 R11

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg      <= 16'h0000;
      pos_reg       <= 2'h0;
      wcnt_reg      <= 3'h0;
      push_reg      <= 1'b0;
      push_data_reg <= 17'h00000;
      nack_reg      <= 1'b0;
      crc_err_reg   <= 1'b0;
      flow_reg      <= 16'h0000;
      temp_reg      <= 16'h0000;
    end else begin
      if (push_reg && push_ready) push_reg <= 1'b0;
      if (go) begin
        pos_reg     <= 2'h0;
        wcnt_reg    <= 3'h0;
        nack_reg    <= 1'b0;
        crc_err_reg <= 1'b0;
      end
      if (byte_done && nack_seen) nack_reg <= 1'b1;
      if (byte_done && (txn_reg == fscrc_pkg::TXN_READ) && (idx_reg != 5'h00)) begin
        if (pos_reg == fscrc_pkg::POS_CRC) begin
          pos_reg       <= 2'h0;
          wcnt_reg      <= wcnt_reg + 3'h1;
          push_reg      <= 1'b1;
          push_data_reg <= {crc_ok, word_reg}; // R11
          if (!crc_ok) crc_err_reg <= 1'b1; // R11
          if (crc_ok && !idm_reg && (wcnt_reg == 3'h0)) flow_reg <= $signed(word_reg) / fscrc_pkg::FLOW_SCALE; // R9
          if (crc_ok && !idm_reg && (wcnt_reg == 3'h1)) temp_reg <= $signed(word_reg) / fscrc_pkg::TEMP_SCALE; // R10
        end else begin
          word_reg <= {word_reg[7:0], rx_reg[8:1]};
          pos_reg  <= pos_reg + 2'h1;
        end
      end
    end
  end

  fscrc_fifo #(.W(17), .D(16)) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (push_reg),
    .in_ready  (push_ready),
    .in_data   (push_data_reg),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  assign busy               = state_reg != fscrc_pkg::H_IDLE;
  assign nack_err           = nack_reg;
  assign crc_err            = crc_err_reg;
  assign flow_mlph          = flow_reg;
  assign temp_c             = temp_reg;
  assign link.scl           = scl_reg;
  assign link.sda_host_o    = 1'b0;
  assign link.sda_host_oe_n = oe_n_reg;

endmodule // fscrc_host

// ===== test/fscrc_sva.sv
// link assertions for the flow sensor readout
module fscrc_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe_n,
  input wire logic sda_host_o,
  input wire logic sda_host_oe_n
);
  logic [7:0] lo_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) lo_reg <= 8'h00;
    else lo_reg <= scl ? 8'h00 : lo_reg + {7'h00, lo_reg != 8'hFF};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // link checks
  // ----
  a_dev_pull_low: assert property (sda_dev_o == 1'b0) else $error("dev data high");
  a_host_pull_low: assert property (sda_host_o == 1'b0) else $error("host data high");
  a_no_clash: assert property (scl && !sda_host_oe_n |-> sda_dev_oe_n) else $error("both drive");
  a_dev_scl_low: assert property ($changed(sda_dev_oe_n) |-> !scl && lo_reg < 8'h10)
    else $error("dev sda late");
  a_scl_high_hold: assert property ($rose(scl) |=> $stable(scl) [*8]) else $error("scl high short");
  a_scl_low_hold: assert property ($fell(scl) |=> $stable(scl) [*8]) else $error("scl low short");
  a_reset_idle: assert property ($rose(rst_n) |-> scl && sda_host_oe_n && sda_dev_oe_n)
    else $error("link busy");
  a_free_at_frame: assert property (scl && $changed(sda_host_oe_n) |-> sda_dev_oe_n)
    else $error("dev holds sda");
endmodule // fscrc_sva

// ===== test/fscrc_tb_top.sv
// self-checking bench for the flow sensor readout link
module fscrc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] PC = 24'h3C3C3C; // arbitrary product code
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic id_req = 1'b0;
  logic meas_req = 1'b0;
  logic word_ready = 1'b0;
  logic [7:0] revision;
  logic [63:0] serial_no;
  logic [15:0] flow_raw, temp_raw, flow_mlph, temp_c;
  logic id_armed, busy, nack_err, crc_err, word_valid;
  logic [16:0] word_data;
  logic [7:0] sh;
  logic [7:0] got[$], exp[$];
  logic [15:0] wexp[$];
  int nb = 0;
  int cyc = 0;
  int miscompares = 0;
  int n_compared = 0;
  fscrc_if link_if ();
  always #10 core_clk = ~core_clk;
  fscrc_dev #(.PROD_CODE(PC)) fscrc_dev_inst (.link(link_if.dev), .*);
  fscrc_host fscrc_host_inst (.link(link_if.host), .*);
  fscrc_sva fscrc_sva_inst (.core_clk(core_clk), .rst_n(rst_n), .scl(link_if.scl),
    .sda_dev_o(link_if.sda_dev_o), .sda_dev_oe_n(link_if.sda_dev_oe_n),
    .sda_host_o(link_if.sda_host_o), .sda_host_oe_n(link_if.sda_host_oe_n));
  // ----
  // wire snoop and helpers
  // ----
  always @(negedge link_if.sda) if (link_if.scl) nb = 0;
  always @(posedge link_if.scl) begin
    nb++;
    sh = {sh[6:0], link_if.sda};
    if (nb == 8) got.push_back(sh);
    if (nb == 9) nb = 0;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  function automatic logic [7:0] crc_of(input logic [15:0] w);
    logic [7:0] c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic put_word(input logic [15:0] w);
    exp.push_back(w[15:8]);
    exp.push_back(w[7:0]);
    exp.push_back(crc_of(w));
    wexp.push_back(w);
  endtask
  task automatic run(input bit id, input string nm);
    got = {};
    if (id) id_req <= 1'b1;
    else meas_req <= 1'b1;
    @(posedge core_clk);
    id_req <= 1'b0;
    meas_req <= 1'b0;
    @(posedge core_clk);
    chk(busy, 1, "busy");
    while (busy !== 1'b0) @(posedge core_clk);
    chk(got.size(), exp.size(), "byte count");
    foreach (exp[i]) chk(got[i], exp[i], "wire byte");
    chk({nack_err, crc_err, id_armed}, 0, "flags");
    $display("test %s done", nm);
  endtask
  task automatic drain();
    while (wexp.size() > 0) begin
      while (word_valid !== 1'b1) @(posedge core_clk);
      chk({word_valid, word_data}, {2'b11, wexp.pop_front()}, "fifo word");
      word_ready <= 1'b1;
      @(posedge core_clk);
      word_ready <= 1'b0;
      @(posedge core_clk);
    end
    chk(word_valid, 0, "fifo left");
  endtask
  task automatic ident();
    serial_no <= {$urandom, $urandom};
    @(posedge core_clk);
    exp = {8'h80, 8'h36, 8'h7C, 8'h80, 8'hE1, 8'h02, 8'h81};
    put_word(PC[23:8]);
    put_word({PC[7:0], revision});
    for (int i = 3; i >= 0; i--) put_word(serial_no[16*i +: 16]);
    run(1'b1, "ident");
  endtask
  task automatic meas(input logic [15:0] f);
    logic [15:0] fx;
    logic [15:0] ef;
    logic [15:0] et;
    flow_raw <= f;
    temp_raw <= 16'($urandom);
    @(posedge core_clk);
    fx = ($signed(f) > 16'sd26000) ? 16'd26000 : f;
    fx = ($signed(fx) < -16'sd26000) ? -16'sd26000 : fx;
    ef = $signed(fx) / 16'sd20;
    et = $signed(temp_raw) / 16'sd200;
    exp = {8'h81};
    put_word(fx);
    put_word(temp_raw);
    run(1'b0, "measure");
    chk(flow_mlph, ef, "flow scale");
    chk(temp_c, et, "temp scale");
  endtask
  // ----
  // tests
  // ----
  initial begin
    void'($urandom(32'h7E91));
    revision <= 8'($urandom);
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    ident();
    meas(16'h8000);
    ident();
    meas(16'd26000);
    fork
      meas(16'h9A70);
      begin
        repeat (200 * fscrc_pkg::QUARTER_CYC) @(posedge core_clk);
        chk({busy, word_valid}, 2'b11, "stall busy");
        chk(link_if.scl, 0, "stall scl");
        drain();
      end
    join
    meas(16'($urandom));
    drain();
    meas(16'h6591);
    drain();
    final_report();
  end
endmodule // fscrc_tb_top
